// ---- core/olf_pkg.sv ----
package olf_pkg;
   // register offsets (byte addresses)
   localparam logic [7:0] OLF_CFG_OFS = 8'h1c;
   localparam logic [7:0] OLF_TL_OFS = 8'h20;
   localparam logic [7:0] OLF_BR_OFS = 8'h24;
   localparam logic [7:0] OLF_KEY_OFS = 8'h28;
   localparam logic [7:0] OLF_SRC_OFS = 8'h2c;
   localparam logic [7:0] OLF_FILL_OFS = 8'h30;
   localparam logic [7:0] OLF_DECOMP_OFS = 8'h34;
   localparam logic [7:0] OLF_STAT_OFS = 8'h44;
   // layer config fields
   localparam int OLF_VFLIP_BIT = 30;
   localparam int OLF_BLEND_BIT = 29;
   localparam int OLF_ACTIVE_BIT = 28;
   localparam int OLF_SKIP_BIT = 27;
   localparam int OLF_PRELOAD_BIT = 26;
   localparam int OLF_PITCH_LSB = 13;
   localparam int OLF_KEY_EN_BIT = 12;
   localparam int OLF_OPACITY_LSB = 4;
   localparam int OLF_ALPHA_SEL_BIT = 3;
   localparam int OLF_FMT_LSB = 0;
   // position fields
   localparam int OLF_Y_LSB = 16;
   localparam int OLF_X_LSB = 0;
   // color key and fill fields
   localparam int OLF_KEY_MASK_LSB = 24;
   localparam int OLF_RED_LSB = 16;
   localparam int OLF_GREEN_LSB = 8;
   localparam int OLF_BLUE_LSB = 0;
   localparam int OLF_ORDER_BIT = 25;
   localparam int OLF_FILL_MODE_BIT = 24;
   // decompression fields
   localparam int OLF_COLS_LSB = 13;
   localparam int OLF_HALFWORDS_LSB = 1;
   localparam int OLF_DECOMP_EN_BIT = 0;
   // writable bit masks; other bits read as zero
   localparam logic [31:0] OLF_CFG_MASK = 32'h7fff_ffff;
   localparam logic [31:0] OLF_POS_MASK = 32'h07ff_07ff;
   localparam logic [31:0] OLF_FILL_MASK = 32'h03ff_ffff;
   localparam logic [31:0] OLF_DECOMP_MASK = 32'h00ff_ffff;
   localparam logic [31:0] OLF_REG_RESET = 32'h0000_0000;
   // fetch and pixel constants
   localparam logic [15:0] OLF_PRELOAD_BYTES = 16'h0040;
   localparam logic [15:0] OLF_DECOMP_BYTES_PER_HW = 16'h0006;
   localparam logic [7:0] OLF_OPAQUE = 8'hff;

   typedef enum logic [2:0] {
      OLF_FMT_RGB565 = 3'h0,
      OLF_FMT_RGB888 = 3'h1,
      OLF_FMT_ARGB8888 = 3'h2,
      OLF_FMT_ARGB8565 = 3'h3,
      OLF_FMT_RGB332 = 3'h4,
      OLF_FMT_A8 = 3'h5,
      OLF_FMT_L8 = 3'h6,
      OLF_FMT_RSVD = 3'h7
   } olf_fmt_t;

   typedef enum logic [0:0] {
      OLF_FETCH_IDLE = 1'b0,
      OLF_FETCH_REQ = 1'b1
   } olf_fetch_state_t;

   // bytes per pixel of each format, zero for the reserved code
   function automatic logic [2:0] olf_bytes_per_pixel(input logic [2:0] fmt);
      unique case (fmt)
         OLF_FMT_RGB565: olf_bytes_per_pixel = 3'h2;
         OLF_FMT_RGB888: olf_bytes_per_pixel = 3'h3;
         OLF_FMT_ARGB8888: olf_bytes_per_pixel = 3'h4;
         OLF_FMT_ARGB8565: olf_bytes_per_pixel = 3'h3;
         OLF_FMT_RGB332: olf_bytes_per_pixel = 3'h1;
         OLF_FMT_A8: olf_bytes_per_pixel = 3'h1;
         OLF_FMT_L8: olf_bytes_per_pixel = 3'h1;
         default: olf_bytes_per_pixel = 3'h0;
      endcase
   endfunction

   // inclusive span of two 11-bit coordinates
   function automatic logic [11:0] olf_span(input logic [10:0] lo,
                                            input logic [10:0] hi);
      olf_span = (hi >= lo) ? ({1'b0, hi} - {1'b0, lo} + 12'h001) : 12'h000;
   endfunction
endpackage

// ---- core/olf_pixel_unpack.sv ----
`timescale 1ns/1ns
module olf_pixel_unpack
   import olf_pkg::*;
(
   input wire logic [31:0] word,
   input wire logic [2:0] fmt,
   input wire logic swap_order,
   output logic [7:0] red,
   output logic [7:0] green,
   output logic [7:0] blue,
   output logic [7:0] alpha,
   output logic known
);
   logic [4:0] r5;
   logic [5:0] g6;
   logic [4:0] b5;

   always_comb
   begin
      // 565 field order selected by the byte order bit
      if (swap_order)
      begin
         g6 = {word[2:0], word[15:13]};
         r5 = word[12:8];
         b5 = word[7:3];
      end
      else
      begin
         r5 = word[15:11];
         g6 = word[10:5];
         b5 = word[4:0];
      end
   end

   always_comb
   begin
      red = 8'h00;
      green = 8'h00;
      blue = 8'h00;
      alpha = OLF_OPAQUE;
      known = 1'b1;
      unique case (olf_fmt_t'(fmt))
         OLF_FMT_RGB565, OLF_FMT_ARGB8565:
         begin
            red = {r5, r5[4:2]};
            green = {g6, g6[5:4]};
            blue = {b5, b5[4:2]};
            if (fmt == OLF_FMT_ARGB8565)
            begin
               alpha = word[23:16];
            end
         end
         OLF_FMT_RGB888, OLF_FMT_ARGB8888:
         begin
            red = word[23:16];
            green = word[15:8];
            blue = word[7:0];
            if (fmt == OLF_FMT_ARGB8888)
            begin
               alpha = word[31:24];
            end
         end
         OLF_FMT_RGB332:
         begin
            red = {word[7:5], word[7:5], word[7:6]};
            green = {word[4:2], word[4:2], word[4:3]};
            blue = {word[1:0], word[1:0], word[1:0], word[1:0]};
         end
         OLF_FMT_A8:
         begin
            alpha = word[7:0];
         end
         OLF_FMT_L8:
         begin
            red = word[7:0];
            green = word[7:0];
            blue = word[7:0];
         end
         OLF_FMT_RSVD:
         begin
            known = 1'b0;
         end
      endcase
   end
endmodule

// ---- core/olf_line_fetch.sv ----
`timescale 1ns/1ns
module olf_line_fetch
   import olf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [31:0] src_addr,
   input wire logic [12:0] pitch,
   input wire logic skip_two,
   input wire logic vflip,
   input wire logic [11:0] lines,
   input wire logic [15:0] line_len,
   input wire logic mem_ack,
   output logic mem_req,
   output logic [31:0] mem_addr,
   output logic [15:0] mem_len,
   output logic busy,
   output logic [11:0] lines_done
);
   olf_fetch_state_t state_q, state_d;
   logic [31:0] addr_q, addr_d;
   logic [11:0] done_q, done_d;
   logic [13:0] stride;
   logic [31:0] last_ofs;

   // one or two source lines per output line pitch
   assign stride = skip_two ? {pitch, 1'b0} : {1'b0, pitch};
   assign last_ofs = 32'(({20'h0, lines} - 32'h1) * {18'h0, stride});

   always_comb
   begin
      state_d = state_q;
      addr_d = addr_q;
      done_d = done_q;
      unique case (state_q)
         OLF_FETCH_IDLE:
         begin
            if (start && lines != 12'h000)
            begin
               state_d = OLF_FETCH_REQ;
               done_d = 12'h000;
               // reversed line order starts at the last line
               addr_d = vflip ? src_addr + last_ofs : src_addr;
            end
         end
         OLF_FETCH_REQ:
         begin
            if (mem_ack)
            begin
               done_d = done_q + 12'h001;
               addr_d = vflip ? addr_q - {18'h0, stride}
                              : addr_q + {18'h0, stride};
               if (done_q + 12'h001 >= lines)
               begin
                  state_d = OLF_FETCH_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_q <= OLF_FETCH_IDLE;
         addr_q <= 32'h0000_0000;
         done_q <= 12'h000;
      end
      else
      begin
         state_q <= state_d;
         addr_q <= addr_d;
         done_q <= done_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mem_len <= 16'h0000;
      end
      else if (state_q == OLF_FETCH_IDLE)
      begin
         mem_len <= line_len;
      end
   end

   assign mem_req = (state_q == OLF_FETCH_REQ);
   assign busy = (state_q == OLF_FETCH_REQ);
   assign mem_addr = addr_q;
   assign lines_done = done_q;
endmodule

// ---- core/olf_layer.sv ----
`timescale 1ns/1ns
// Behaviour
// - line skip bit 0 steps one source line, 1 steps two lines
// - preload enable adds 64 extra bytes to each line read
// - 13-bit byte pitch including padding separates source lines
// - color key enable applies masked red, green, blue key filter
// - opacity select 0 takes image alpha, or the blend product when blend multiply is set; 1 takes programmed opacity
// - format codes 0..6 decoded; code 7 reserved
// - byte order bit picks 565 field order
// - per-channel size counts halfwords; line reads six bytes per unit
// - vertical flip fetches lines in reversed order
// - blend multiply makes alpha the upper byte of opacity times image alpha, only when opacity select is 0
module olf_layer
   import olf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic frame_start,
   output logic mem_req,
   output logic [31:0] mem_addr,
   output logic [15:0] mem_len,
   input wire logic mem_ack,
   input wire logic pix_valid,
   input wire logic [31:0] pix_word,
   input wire logic [10:0] pix_x,
   input wire logic [10:0] pix_y,
   output logic out_valid,
   output logic [7:0] out_red,
   output logic [7:0] out_green,
   output logic [7:0] out_blue,
   output logic [7:0] out_alpha
);
   logic [31:0] cfg_q, cfg_d;
   logic [31:0] tl_q, tl_d;
   logic [31:0] br_q, br_d;
   logic [31:0] key_q, key_d;
   logic [31:0] src_q, src_d;
   logic [31:0] fill_q, fill_d;
   logic [31:0] decomp_q, decomp_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] status;
   logic fetch_busy;
   logic [11:0] lines_done;

   // register file writes
   always_comb
   begin
      cfg_d = cfg_q;
      tl_d = tl_q;
      br_d = br_q;
      key_d = key_q;
      src_d = src_q;
      fill_d = fill_q;
      decomp_d = decomp_q;
      if (reg_wr)
      begin
         unique case (reg_addr)
            OLF_CFG_OFS: cfg_d = reg_wdata & OLF_CFG_MASK;
            OLF_TL_OFS: tl_d = reg_wdata & OLF_POS_MASK;
            OLF_BR_OFS: br_d = reg_wdata & OLF_POS_MASK;
            OLF_KEY_OFS: key_d = reg_wdata;
            OLF_SRC_OFS: src_d = reg_wdata;
            OLF_FILL_OFS: fill_d = reg_wdata & OLF_FILL_MASK;
            OLF_DECOMP_OFS: decomp_d = reg_wdata & OLF_DECOMP_MASK;
            default:
            begin
            end
         endcase
      end
   end

   assign status = {4'h0, lines_done, 15'h0000, fetch_busy};

   // read data one cycle after the strobe, zero when unmapped
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (reg_rd)
      begin
         unique case (reg_addr)
            OLF_CFG_OFS: rdata_d = cfg_q;
            OLF_TL_OFS: rdata_d = tl_q;
            OLF_BR_OFS: rdata_d = br_q;
            OLF_KEY_OFS: rdata_d = key_q;
            OLF_SRC_OFS: rdata_d = src_q;
            OLF_FILL_OFS: rdata_d = fill_q;
            OLF_DECOMP_OFS: rdata_d = decomp_q;
            OLF_STAT_OFS: rdata_d = status;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cfg_q <= OLF_REG_RESET;
         tl_q <= OLF_REG_RESET;
         br_q <= OLF_REG_RESET;
         key_q <= OLF_REG_RESET;
         src_q <= OLF_REG_RESET;
         fill_q <= OLF_REG_RESET;
         decomp_q <= OLF_REG_RESET;
         rdata_q <= OLF_REG_RESET;
      end
      else
      begin
         cfg_q <= cfg_d;
         tl_q <= tl_d;
         br_q <= br_d;
         key_q <= key_d;
         src_q <= src_d;
         fill_q <= fill_d;
         decomp_q <= decomp_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // config fields
   logic [2:0] fmt;
   logic alpha_sel;
   logic [7:0] opacity;
   logic key_en;
   logic [12:0] pitch;
   logic preload;
   logic skip_two;
   logic blend_mul;
   logic vflip;
   logic active;
   logic [10:0] left_x;
   logic [10:0] top_y;
   logic [10:0] right_x;
   logic [10:0] bottom_y;
   logic [7:0] key_mask;
   logic [7:0] key_red;
   logic [7:0] key_green;
   logic [7:0] key_blue;
   logic swap_order;
   logic decomp_en;
   logic [11:0] halfwords;

   assign fmt = cfg_q[OLF_FMT_LSB +: 3];
   assign alpha_sel = cfg_q[OLF_ALPHA_SEL_BIT];
   assign opacity = cfg_q[OLF_OPACITY_LSB +: 8];
   assign key_en = cfg_q[OLF_KEY_EN_BIT];
   assign pitch = cfg_q[OLF_PITCH_LSB +: 13];
   assign preload = cfg_q[OLF_PRELOAD_BIT];
   assign skip_two = cfg_q[OLF_SKIP_BIT];
   assign active = cfg_q[OLF_ACTIVE_BIT];
   assign blend_mul = cfg_q[OLF_BLEND_BIT];
   assign vflip = cfg_q[OLF_VFLIP_BIT];
   assign left_x = tl_q[OLF_X_LSB +: 11];
   assign top_y = tl_q[OLF_Y_LSB +: 11];
   assign right_x = br_q[OLF_X_LSB +: 11];
   assign bottom_y = br_q[OLF_Y_LSB +: 11];
   assign key_mask = key_q[OLF_KEY_MASK_LSB +: 8];
   assign key_red = key_q[OLF_RED_LSB +: 8];
   assign key_green = key_q[OLF_GREEN_LSB +: 8];
   assign key_blue = key_q[OLF_BLUE_LSB +: 8];
   assign swap_order = fill_q[OLF_ORDER_BIT];
   assign decomp_en = decomp_q[OLF_DECOMP_EN_BIT];
   assign halfwords = decomp_q[OLF_HALFWORDS_LSB +: 12];

   // bytes read for one source line
   logic [11:0] width_px;
   logic [11:0] height_px;
   logic [15:0] raw_len;
   logic [15:0] line_len;

   assign width_px = olf_span(left_x, right_x);
   assign height_px = olf_span(top_y, bottom_y);

   always_comb
   begin
      if (decomp_en)
      begin
         raw_len = 16'({4'h0, halfwords} * OLF_DECOMP_BYTES_PER_HW);
      end
      else
      begin
         raw_len = 16'({4'h0, width_px} * {13'h0, olf_bytes_per_pixel(fmt)});
      end
      line_len = preload ? raw_len + OLF_PRELOAD_BYTES : raw_len;
   end

   olf_line_fetch u_fetch (
      .clk(clk),
      .rst(rst),
      .start(frame_start & active),
      .src_addr(src_q),
      .pitch(pitch),
      .skip_two(skip_two),
      .vflip(vflip),
      .lines(height_px),
      .line_len(line_len),
      .mem_ack(mem_ack),
      .mem_req(mem_req),
      .mem_addr(mem_addr),
      .mem_len(mem_len),
      .busy(fetch_busy),
      .lines_done(lines_done)
   );

   // pixel path
   logic [7:0] img_red;
   logic [7:0] img_green;
   logic [7:0] img_blue;
   logic [7:0] img_alpha;
   logic fmt_known;

   olf_pixel_unpack u_unpack (
      .word(pix_word),
      .fmt(fmt),
      .swap_order(swap_order),
      .red(img_red),
      .green(img_green),
      .blue(img_blue),
      .alpha(img_alpha),
      .known(fmt_known)
   );

   logic in_rect;
   logic key_hit;
   logic [15:0] alpha_prod;
   logic [7:0] alpha_sel_val;
   logic valid_d;
   logic [7:0] red_d;
   logic [7:0] green_d;
   logic [7:0] blue_d;
   logic [7:0] alpha_d;
   logic valid_q;
   logic [7:0] red_q;
   logic [7:0] green_q;
   logic [7:0] blue_q;
   logic [7:0] alpha_q;

   always_comb
   begin
      in_rect = pix_x >= left_x && pix_x <= right_x &&
                pix_y >= top_y && pix_y <= bottom_y;
      key_hit = key_en &&
                (img_red & key_mask) == (key_red & key_mask) &&
                (img_green & key_mask) == (key_green & key_mask) &&
                (img_blue & key_mask) == (key_blue & key_mask);
      alpha_prod = {8'h00, opacity} * {8'h00, img_alpha};
      if (alpha_sel)
      begin
         alpha_sel_val = opacity;
      end
      else if (blend_mul)
      begin
         alpha_sel_val = alpha_prod[15:8];
      end
      else
      begin
         alpha_sel_val = img_alpha;
      end
      valid_d = pix_valid && active && in_rect && fmt_known;
      red_d = img_red;
      green_d = img_green;
      blue_d = img_blue;
      alpha_d = key_hit ? 8'h00 : alpha_sel_val;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         valid_q <= 1'b0;
         red_q <= 8'h00;
         green_q <= 8'h00;
         blue_q <= 8'h00;
         alpha_q <= 8'h00;
      end
      else
      begin
         valid_q <= valid_d;
         red_q <= red_d;
         green_q <= green_d;
         blue_q <= blue_d;
         alpha_q <= alpha_d;
      end
   end

   assign out_valid = valid_q;
   assign out_red = red_q;
   assign out_green = green_q;
   assign out_blue = blue_q;
   assign out_alpha = alpha_q;
endmodule

// ---- verification/olf_layer_chk.sv ----
`timescale 1ns/1ns
module olf_layer_chk
   import olf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   input wire logic [15:0] mem_len,
   input wire logic mem_ack,
   input wire logic pix_valid,
   input wire logic [10:0] pix_x,
   input wire logic [10:0] pix_y,
   input wire logic out_valid,
   input wire logic [7:0] out_alpha
);
   logic [31:0] cfg_q, cfg_d, tl_q, tl_d, br_q, br_d, stride;
   logic ok_px;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // shadow copies of the layer setup
   always_comb
   begin
      cfg_d = cfg_q;
      tl_d = tl_q;
      br_d = br_q;
      if (reg_wr && reg_addr == OLF_CFG_OFS)
         cfg_d = reg_wdata;
      if (reg_wr && reg_addr == OLF_TL_OFS)
         tl_d = reg_wdata;
      if (reg_wr && reg_addr == OLF_BR_OFS)
         br_d = reg_wdata;
   end

   always_ff @(posedge clk)
   begin
      cfg_q <= rst ? 32'h0 : cfg_d;
      tl_q <= rst ? 32'h0 : tl_d;
      br_q <= rst ? 32'h0 : br_d;
   end

   assign stride = {19'h0, cfg_q[25:13]} << cfg_q[27];
   assign ok_px = pix_x >= tl_q[10:0] && pix_x <= br_q[10:0]
      && pix_y >= tl_q[26:16] && pix_y <= br_q[26:16]
      && cfg_q[28] && cfg_q[2:0] != 3'h7;

   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside read cycle");
   a_req_hold: assert property (mem_req && !mem_ack |=> mem_req
      && $stable(mem_addr) && $stable(mem_len))
      else $error("line request changed before ack");
   a_len_const: assert property (mem_req && $past(mem_req)
      |-> $stable(mem_len))
      else $error("line length changed within frame");
   a_addr_step: assert property ($past(mem_req && mem_ack) && mem_req
      |-> mem_addr == (cfg_q[30] ? $past(mem_addr) - stride
      : $past(mem_addr) + stride))
      else $error("line address step wrong");
   a_pix_shown: assert property (pix_valid && ok_px |=> out_valid)
      else $error("pixel inside layer not shown");
   a_pix_hidden: assert property (pix_valid && !ok_px |=> !out_valid)
      else $error("pixel outside layer shown");
   a_out_cause: assert property (out_valid |-> $past(pix_valid))
      else $error("output without input pixel");
   a_opacity_sel: assert property (out_valid && cfg_q[3] && !cfg_q[12]
      && !cfg_q[29] |-> out_alpha == cfg_q[11:4])
      else $error("programmed opacity not used");

   c_vflip: cover property ($rose(mem_req) && cfg_q[30]);
   c_blend: cover property (out_valid && cfg_q[29]);
   c_skip: cover property ($rose(mem_req) && cfg_q[27]);
endmodule

bind olf_layer olf_layer_chk olf_layer_chk_i (.clk(clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
   .mem_addr(mem_addr), .mem_len(mem_len), .mem_ack(mem_ack),
   .pix_valid(pix_valid), .pix_x(pix_x), .pix_y(pix_y),
   .out_valid(out_valid), .out_alpha(out_alpha));

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
module tb_top
   import olf_pkg::*;
;
   logic clk, rst, reg_wr, reg_rd, frame_start, mem_ack, mem_req;
   logic pix_valid, out_valid;
   logic [7:0] reg_addr, out_red, out_green, out_blue, out_alpha;
   logic [31:0] reg_wdata, reg_rdata, mem_addr, pix_word;
   logic [15:0] mem_len;
   logic [10:0] pix_x, pix_y;
   int miscompares, n_checks, cycles;

   olf_layer olf_layer_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .frame_start(frame_start), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_len(mem_len), .mem_ack(mem_ack),
      .pix_valid(pix_valid), .pix_word(pix_word), .pix_x(pix_x),
      .pix_y(pix_y), .out_valid(out_valid), .out_red(out_red),
      .out_green(out_green), .out_blue(out_blue), .out_alpha(out_alpha));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // hang guard
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         miscompares++;
         report_and_stop();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", exp, reg_rdata);
   endtask

   task automatic t_regs();
      logic [7:0] ofs [7];
      logic [31:0] msk [7];
      ofs = '{OLF_CFG_OFS, OLF_TL_OFS, OLF_BR_OFS, OLF_KEY_OFS, OLF_SRC_OFS,
         OLF_FILL_OFS, OLF_DECOMP_OFS};
      msk = '{32'h7fff_ffff, 32'h07ff_07ff, 32'h07ff_07ff, 32'hffff_ffff,
         32'hffff_ffff, 32'h03ff_ffff, 32'h00ff_ffff};
      for (int i = 0; i < 7; i++)
      begin
         rd(ofs[i], 32'h0);
         wr(ofs[i], 32'hffff_ffff);
         rd(ofs[i], msk[i]);
         wr(ofs[i], 32'h0);
      end
      rd(8'h50, 32'h0);
   endtask

   // three lines per frame, acked one by one
   task automatic frame(input logic [31:0] cfg, input logic [31:0] a0,
      input logic [31:0] step, input logic [15:0] len);
      int k;
      wr(OLF_CFG_OFS, cfg);
      @(posedge clk);
      frame_start <= 1'b1;
      @(posedge clk);
      frame_start <= 1'b0;
      for (int n = 0; n < 3; n++)
      begin
         k = 0;
         // look between edges, where the request is settled
         @(negedge clk);
         while (mem_req !== 1'b1 && k < 20)
         begin
            @(negedge clk);
            k++;
         end
         chk("mem_addr", a0 + step * n, mem_addr);
         chk("mem_len", {16'h0, len}, {16'h0, mem_len});
         @(posedge clk);
         mem_ack <= 1'b1;
         @(posedge clk);
         mem_ack <= 1'b0;
      end
      @(negedge clk);
      chk("mem_req", 32'h0, {31'h0, mem_req});
   endtask

   task automatic t_fetch();
      wr(OLF_SRC_OFS, 32'h0000_1000);
      wr(OLF_BR_OFS, 32'h0002_0009);
      frame(32'h1020_0000, 32'h1000, 32'h100, 16'h0014);
      frame(32'h1c20_0002, 32'h1000, 32'h200, 16'h0068);
      frame(32'h5020_0001, 32'h1200, 32'hffff_ff00, 16'h001e);
      wr(OLF_DECOMP_OFS, 32'h0080_000b);
      frame(32'h1020_0000, 32'h1000, 32'h100, 16'h001e);
      wr(OLF_DECOMP_OFS, 32'h0);
      rd(OLF_STAT_OFS, 32'h0003_0000);
   endtask

   task automatic pix(input logic [31:0] w, input logic [10:0] x,
      input logic [10:0] y, input logic v, input logic [31:0] argb);
      @(posedge clk);
      pix_valid <= 1'b1;
      pix_word <= w;
      pix_x <= x;
      pix_y <= y;
      @(posedge clk);
      pix_valid <= 1'b0;
      #1;
      chk("out_valid", {31'h0, v}, {31'h0, out_valid});
      if (v)
         chk("out_argb", argb, {out_alpha, out_red, out_green, out_blue});
   endtask

   task automatic t_pix();
      logic [31:0] w [7];
      logic [31:0] e [7];
      w = '{32'hf800, 32'h112233, 32'h8011_2233, 32'h7f_f800, 32'he0,
         32'h55, 32'h44};
      e = '{32'hffff_0000, 32'hff11_2233, 32'h8011_2233, 32'h7fff_0000,
         32'hffff_0000, 32'h5500_0000, 32'hff44_4444};
      wr(OLF_TL_OFS, 32'h0002_0002);
      wr(OLF_BR_OFS, 32'h0005_0005);
      for (int i = 0; i < 7; i++)
      begin
         wr(OLF_CFG_OFS, 32'h1000_0000 | i);
         pix(w[i], 11'h3, 11'h3, 1'b1, e[i]);
      end
      wr(OLF_CFG_OFS, 32'h1000_0007);
      pix(32'h8011_2233, 11'h3, 11'h3, 1'b0, 32'h0);
      wr(OLF_CFG_OFS, 32'h1000_0002);
      pix(32'h8011_2233, 11'h2, 11'h5, 1'b1, 32'h8011_2233);
      pix(32'h8011_2233, 11'h6, 11'h3, 1'b0, 32'h0);
      pix(32'h8011_2233, 11'h3, 11'h1, 1'b0, 32'h0);
      wr(OLF_CFG_OFS, 32'h1000_0000);
      pix(32'h7, 11'h3, 11'h3, 1'b1, 32'hff00_0039);
      wr(OLF_FILL_OFS, 32'h0200_0000);
      pix(32'h7, 11'h3, 11'h3, 1'b1, 32'hff00_e300);
      pix(32'h1f00, 11'h3, 11'h3, 1'b1, 32'hffff_0000);
      wr(OLF_CFG_OFS, 32'h1000_040a);
      pix(32'h8011_2233, 11'h3, 11'h3, 1'b1, 32'h4011_2233);
      wr(OLF_CFG_OFS, 32'h3000_0802);
      pix(32'h4011_2233, 11'h3, 11'h3, 1'b1, 32'h2011_2233);
      wr(OLF_KEY_OFS, 32'hff11_2233);
      wr(OLF_CFG_OFS, 32'h1000_1002);
      pix(32'h8011_2233, 11'h3, 11'h3, 1'b1, 32'h0011_2233);
      pix(32'h8011_2234, 11'h3, 11'h3, 1'b1, 32'h8011_2234);
   endtask

   initial
   begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      frame_start = 1'b0;
      mem_ack = 1'b0;
      pix_valid = 1'b0;
      pix_word = 32'h0;
      pix_x = 11'h0;
      pix_y = 11'h0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_fetch();
      t_pix();
      report_and_stop();
   end
endmodule
